// ===== common/hub_strap_defs.svh
// Purpose: offsets, field positions and reset values of the hub pin block
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef HUB_STRAP_DEFS_SVH
`define HUB_STRAP_DEFS_SVH

`define HSP_ADDR_W          8
`define HSP_DATA_W          32
`define HSP_OFF_CTRL        8'h00
`define HSP_OFF_STATUS      8'h04
`define HSP_WORD_LSB        2

// control register fields
`define HSP_CTRL_DYN        0
`define HSP_CTRL_SELF       1
`define HSP_CTRL_ATTACH     2
`define HSP_CTRL_RESET      3'h0

// status register fields
`define HSP_ST_STRAP_LO     0
`define HSP_ST_STRAP_HI     1
`define HSP_ST_LOCAL        2
`define HSP_ST_SELFPWR      3
`define HSP_ST_ATTACHED     4
`define HSP_ST_SMBUS        5
`define HSP_ST_INDICATOR    6
`define HSP_ST_ROLE_LO      7
`define HSP_ST_ROLE_HI      8

// fixed-port strap codes
`define HSP_STRAP_NONE      2'h0
`define HSP_STRAP_PORT1     2'h1
`define HSP_STRAP_PORT12    2'h2
`define HSP_STRAP_RSVD      2'h3

`define HSP_RESP_OKAY       2'h0
`define HSP_RESP_SLVERR     2'h2

`endif

// ===== common/hub_strap_pkg.sv
// Purpose: types shared by the hub pin block
// Assumes: nothing
// Notes:   constants live in hub_strap_defs.svh
package hub_strap_pkg;

    // role the shared pin plays at the moment
    typedef enum logic [1:0] {
        ROLE_STRAP_SAMPLE,
        ROLE_INDICATOR,
        ROLE_SENSE_TRACK,
        ROLE_SENSE_FROZEN
    } pin_role_t;

endpackage : hub_strap_pkg

// ===== design/sync_2ff.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock; clock enable freezes the flops
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // no reset: strap capture must see the pin while reset is held
    always_ff @(posedge clk) begin
        if (ce) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : sync_2ff

`default_nettype wire

// ===== design/reset_capture.sv
// Purpose: follows a value while reset is held, keeps it after release
// Assumes: synchronous active-high reset
// Notes:   the value held is the one seen at the last reset edge
`timescale 1ns/1ps
`default_nettype none

module reset_capture #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= d;
        end
    end

endmodule : reset_capture

`default_nettype wire

// ===== design/hub_status_strap_pins.sv
// Purpose: shared suspend-indicator / local-supply / strap pin of a hub
// Assumes: clk 50 MHz, synchronous active-high reset, AXI4-Lite slave
// Notes:   strap inputs from pins pass two flops first; the mode input comes from the hub core unsynchronised
//
// Summary of operation
// - the indicator is negated while unconfigured or suspended.
// - the indicator is asserted only while configured and active.
// - with dynamic power on in SMBus mode, local supply sense picks bus/self powered.
// - local supply sense is sampled during reset, before attach.
// - once the attach bit is set, local supply sense changes are ignored.
// - sense low means no local supply, high means local supply present.
// - the pin means local supply sense only in SMBus configuration mode.
// - in strap mode the pin is strap bit 0 in reset, indicator after.
// - strap 0 none fixed, 1 port 1 fixed, 2 ports 1-2 fixed, 3 reserved.
// - both strap bits are latched as reset is released.
`timescale 1ns/1ps
`default_nettype none
`include "hub_strap_defs.svh"

module hub_status_strap_pins
    import hub_strap_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    // shared pin: strap bit 0 / indicator / local supply sense
    input  wire logic                   sharedPinIn,
    output var  logic                   sharedPinOut,
    output var  logic                   sharedPinOe,
    // strap bit 1 pin, sampled only
    input  wire logic                   strapMsbPinIn,
    // hub core state, same clock
    input  wire logic                   smbusConfigMode,
    input  wire logic                   hubConfigured,
    input  wire logic                   hubSuspended,
    // results for the hub core
    output var  logic                   suspendIndicatorOut,
    output var  logic                   reportSelfPowered,
    output var  logic                   attachState,
    output var  logic                   port1Fixed,
    output var  logic                   port2Fixed,
    output var  logic                   strapReserved,
    // AXI4-Lite slave
    input  wire logic                   awvalid,
    output var  logic                   awready,
    input  wire logic [`HSP_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   wvalid,
    output var  logic                   wready,
    input  wire logic [`HSP_DATA_W-1:0] wdata,
    input  wire logic [3:0]             wstrb,
    output var  logic                   bvalid,
    input  wire logic                   bready,
    output var  logic [1:0]             bresp,
    input  wire logic                   arvalid,
    output var  logic                   arready,
    input  wire logic [`HSP_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    output var  logic                   rvalid,
    input  wire logic                   rready,
    output var  logic [`HSP_DATA_W-1:0] rdata,
    output var  logic [1:0]             rresp
);

    logic                   pinSync;
    logic                   msbSync;
    logic [1:0]             strapHeld;
    logic [1:0]             strap_q;
    logic                   smbusMode_q;
    logic                   localSupply_q;
    logic                   dynPowerEn_q;
    logic                   staticSelf_q;
    logic                   attach_q;
    pin_role_t              role_q;
    pin_role_t              role_d;
    logic                   ledActiveLow_q;
    logic                   indicator_d;
    logic                   awHeld_q;
    logic                   wHeld_q;
    logic [`HSP_ADDR_W-1:0] awAddr_q;
    logic [`HSP_DATA_W-1:0] wData_q;
    logic [3:0]             wStrb_q;
    logic                   doWrite;
    logic                   wrCtrl;
    logic [`HSP_DATA_W-1:0] readWord;
    logic [1:0]             readResp;
    logic                   unusedBits;

    // a literal cannot be part-selected, so the offsets get a named home
    localparam logic [`HSP_ADDR_W-1:0] ctrlOff   = `HSP_OFF_CTRL;
    localparam logic [`HSP_ADDR_W-1:0] statusOff = `HSP_OFF_STATUS;

    // protection bits carry no meaning here
    assign unusedBits = ^{awprot, arprot, wStrb_q[3:1]};

    // pins come from outside the clock domain
    sync_2ff #(
        .WIDTH (1)
    ) u_sharedSync (
        .clk     (clk),
        .ce      (ce),
        .async_i (sharedPinIn),
        .sync_o  (pinSync)
    );

    sync_2ff #(
        .WIDTH (1)
    ) u_msbSync (
        .clk     (clk),
        .ce      (ce),
        .async_i (strapMsbPinIn),
        .sync_o  (msbSync)
    );

    // value seen on the last reset edge is the strap
    reset_capture #(
        .WIDTH (2)
    ) u_strapCapture (
        .clk   (clk),
        .reset (reset),
        .d     ({msbSync, pinSync}),
        .q     (strapHeld)
    );

    // strap copy kept for decode; never touched outside reset
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_q <= {msbSync, pinSync};
        end
    end

    // mode select also caught at reset release, held afterwards
    always_ff @(posedge clk) begin
        if (reset) begin
            smbusMode_q <= smbusConfigMode;
        end
    end

    // pin role sequencing
    always_comb begin
        role_d = role_q;
        case (role_q)
            ROLE_STRAP_SAMPLE: begin
                if (smbusMode_q) begin
                    role_d = ROLE_SENSE_TRACK;
                end else begin
                    role_d = ROLE_INDICATOR;
                end
            end
            ROLE_SENSE_TRACK: begin
                if (attach_q) begin
                    role_d = ROLE_SENSE_FROZEN;
                end
            end
            ROLE_INDICATOR: begin
                role_d = ROLE_INDICATOR;
            end
            ROLE_SENSE_FROZEN: begin
                role_d = ROLE_SENSE_FROZEN;
            end
            default: begin
                role_d = ROLE_STRAP_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            role_q <= ROLE_STRAP_SAMPLE;
        end else if (ce) begin
            role_q <= role_d;
        end
    end

    // local supply sense: followed in reset and, in the sense role, until attach
    always_ff @(posedge clk) begin
        if (reset) begin
            localSupply_q <= pinSync;
        end else if (ce && role_q == ROLE_SENSE_TRACK && !attach_q) begin
            localSupply_q <= pinSync;
        end
    end

    // a strap pulled high means the led sinks, so drive it active low
    always_ff @(posedge clk) begin
        if (reset) begin
            ledActiveLow_q <= 1'b0;
        end else if (ce && role_q == ROLE_STRAP_SAMPLE) begin
            ledActiveLow_q <= strapHeld[0];
        end
    end

    // indicator: configured and not suspended
    assign indicator_d = hubConfigured && !hubSuspended;

    always_ff @(posedge clk) begin
        if (reset) begin
            suspendIndicatorOut <= 1'b0;
        end else if (ce) begin
            suspendIndicatorOut <= indicator_d;
        end
    end

    // pin drive: only in the indicator role, never during reset
    always_ff @(posedge clk) begin
        if (reset) begin
            sharedPinOe  <= 1'b0;
            sharedPinOut <= 1'b0;
        end else if (ce) begin
            sharedPinOe  <= (role_d == ROLE_INDICATOR);
            // polarity flop is not loaded yet on the first edge after reset
            sharedPinOut <= indicator_d ^
                (role_q == ROLE_STRAP_SAMPLE ? strapHeld[0] : ledActiveLow_q);
        end
    end

    // bus or self powered report
    always_ff @(posedge clk) begin
        if (reset) begin
            reportSelfPowered <= 1'b0;
        end else if (ce) begin
            if (dynPowerEn_q && smbusMode_q) begin
                reportSelfPowered <= localSupply_q;
            end else begin
                reportSelfPowered <= staticSelf_q;
            end
        end
    end

    // fixed-port decode; in smbus mode the pin carries no strap
    always_ff @(posedge clk) begin
        if (reset) begin
            port1Fixed    <= 1'b0;
            port2Fixed    <= 1'b0;
            strapReserved <= 1'b0;
        end else if (ce) begin
            port1Fixed    <= 1'b0;
            port2Fixed    <= 1'b0;
            strapReserved <= 1'b0;
            if (!smbusMode_q) begin
                case (strap_q)
                    `HSP_STRAP_NONE: begin
                        port1Fixed <= 1'b0;
                    end
                    `HSP_STRAP_PORT1: begin
                        port1Fixed <= 1'b1;
                    end
                    `HSP_STRAP_PORT12: begin
                        port1Fixed <= 1'b1;
                        port2Fixed <= 1'b1;
                    end
                    `HSP_STRAP_RSVD: begin
                        strapReserved <= 1'b1;
                    end
                    default: begin
                        strapReserved <= 1'b0;
                    end
                endcase
            end
        end
    end

    // AXI write channel: address and data taken in either order
    assign awready = !awHeld_q && !bvalid;
    assign wready  = !wHeld_q && !bvalid;
    assign doWrite = awHeld_q && wHeld_q && !bvalid;
    assign wrCtrl  = doWrite &&
        (awAddr_q[`HSP_ADDR_W-1:`HSP_WORD_LSB] ==
         ctrlOff[`HSP_ADDR_W-1:`HSP_WORD_LSB]);

    always_ff @(posedge clk) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (ce) begin
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid <= 1'b0;
            bresp  <= `HSP_RESP_OKAY;
        end else if (ce) begin
            if (doWrite) begin
                bvalid <= 1'b1;
                if (wrCtrl ||
                    awAddr_q[`HSP_ADDR_W-1:`HSP_WORD_LSB] ==
                    statusOff[`HSP_ADDR_W-1:`HSP_WORD_LSB]) begin
                    bresp <= `HSP_RESP_OKAY;
                end else begin
                    bresp <= `HSP_RESP_SLVERR;
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // control register; attach is set by software, cleared only by reset
    always_ff @(posedge clk) begin
        if (reset) begin
            {attach_q, staticSelf_q, dynPowerEn_q} <= `HSP_CTRL_RESET;
        end else if (ce && wrCtrl && wStrb_q[0]) begin
            dynPowerEn_q <= wData_q[`HSP_CTRL_DYN];
            staticSelf_q <= wData_q[`HSP_CTRL_SELF];
            if (wData_q[`HSP_CTRL_ATTACH]) begin
                attach_q <= 1'b1;
            end
        end
    end

    assign attachState = attach_q;

    // read mux
    always_comb begin
        readWord = '0;
        readResp = `HSP_RESP_OKAY;
        case (araddr[`HSP_ADDR_W-1:`HSP_WORD_LSB])
            ctrlOff[`HSP_ADDR_W-1:`HSP_WORD_LSB]: begin
                readWord[`HSP_CTRL_DYN]    = dynPowerEn_q;
                readWord[`HSP_CTRL_SELF]   = staticSelf_q;
                readWord[`HSP_CTRL_ATTACH] = attach_q;
            end
            statusOff[`HSP_ADDR_W-1:`HSP_WORD_LSB]: begin
                readWord[`HSP_ST_STRAP_LO]  = strap_q[0];
                readWord[`HSP_ST_STRAP_HI]  = strap_q[1];
                readWord[`HSP_ST_LOCAL]     = localSupply_q;
                readWord[`HSP_ST_SELFPWR]   = reportSelfPowered;
                readWord[`HSP_ST_ATTACHED]  = attach_q;
                readWord[`HSP_ST_SMBUS]     = smbusMode_q;
                readWord[`HSP_ST_INDICATOR] = suspendIndicatorOut;
                readWord[`HSP_ST_ROLE_HI:`HSP_ST_ROLE_LO] = role_q;
            end
            default: begin
                readResp = `HSP_RESP_SLVERR;
            end
        endcase
    end

    assign arready = !rvalid;

    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= `HSP_RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= readWord;
                rresp  <= readResp;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule : hub_status_strap_pins

`default_nettype wire

// ===== bench/hub_board_model.sv
// Purpose: board around the shared pin: strap resistors, LED, supply sense
// Assumes: resistors are weak, so the block's own driver wins
// Notes:   in smbus mode the supply sense source owns the pin
`timescale 1ns/1ps
`default_nettype none
module hub_board_model (
    input  wire logic sharedPinOut,
    input  wire logic sharedPinOe,
    input  wire logic senseMode,
    input  wire logic strapLo,
    input  wire logic strapHi,
    input  wire logic supply,
    output var  logic sharedPinIn,
    output var  logic strapMsbPinIn
);
    // released pin falls back to its resistor or the sense level
    always_comb begin
        if (sharedPinOe)
            sharedPinIn = sharedPinOut;
        else
            sharedPinIn = senseMode ? supply : strapLo;
    end
    assign strapMsbPinIn = strapHi;
endmodule : hub_board_model
`default_nettype wire

// ===== bench/hub_status_strap_pins_assertions.sv
// Purpose: concurrent checks on the shared pin block ports
// Assumes: ce held high by the bench
// Notes:   outputs settle on the first edge after reset release
`timescale 1ns/1ps
`default_nettype none
module hub_pin_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic smbusConfigMode,
    input wire logic hubConfigured,
    input wire logic hubSuspended,
    input wire logic sharedPinOut,
    input wire logic sharedPinOe,
    input wire logic suspendIndicatorOut,
    input wire logic attachState,
    input wire logic port1Fixed,
    input wire logic port2Fixed,
    input wire logic strapReserved
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic strapLsb;
    assign strapLsb = (port1Fixed && !port2Fixed) || strapReserved;
    sequence sActive;
        hubConfigured && !hubSuspended;
    endsequence
    sequence sJustReleased;
        $past(reset, 2);
    endsequence
    AST_IND_OFF: assert property (
        !hubConfigured || hubSuspended |=> !suspendIndicatorOut)
        else $error("indicator lit while idle or suspended");
    AST_IND_ON: assert property (
        sActive |=> suspendIndicatorOut)
        else $error("indicator dark while active");
    AST_STRAP_HOLD: assert property (
        !$past(reset, 2) |-> $stable({port1Fixed, port2Fixed, strapReserved}))
        else $error("latched strap moved");
    AST_DECODE: assert property (
        port2Fixed |-> port1Fixed && !strapReserved)
        else $error("strap decode inconsistent");
    AST_SMBUS_QUIET: assert property (
        smbusConfigMode |-> !sharedPinOe && !port1Fixed && !strapReserved)
        else $error("pin used as strap in smbus mode");
    AST_STRAP_DRIVE: assert property (
        !smbusConfigMode && !$past(reset, 2) |-> sharedPinOe)
        else $error("pin not driven after reset");
    AST_OE_RISE: assert property (
        $rose(sharedPinOe) |-> sJustReleased)
        else $error("pin driver enabled late");
    AST_PIN_LED: assert property (
        sharedPinOe |-> sharedPinOut == (suspendIndicatorOut ^ strapLsb))
        else $error("pin level wrong for strap polarity");
    AST_ATTACH_STICKY: assert property (
        attachState |=> attachState)
        else $error("attach state dropped");
endmodule : hub_pin_checker
bind hub_status_strap_pins hub_pin_checker checker_i (
    .clk, .reset, .smbusConfigMode, .hubConfigured, .hubSuspended,
    .sharedPinOut, .sharedPinOe, .suspendIndicatorOut, .attachState,
    .port1Fixed, .port2Fixed, .strapReserved
);
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench of the hub shared pin block
// Assumes: AXI4-Lite master driven on rising edges
// Notes:   ce, prot and strobe lines are held constant
`timescale 1ns/1ps
`default_nettype none
`include "hub_strap_defs.svh"
module testbench;
    logic        clk, reset, ce, sharedPinIn, sharedPinOut, sharedPinOe;
    logic        strapMsbPinIn, smbusConfigMode, hubConfigured, hubSuspended;
    logic        suspendIndicatorOut, reportSelfPowered, attachState;
    logic        port1Fixed, port2Fixed, strapReserved;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, strapLo, strapHi, supply;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [2:0]  awprot, arprot;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          n_fail, checks, cyc;
    hub_status_strap_pins dut (
        .clk, .reset, .ce, .sharedPinIn, .sharedPinOut, .sharedPinOe,
        .strapMsbPinIn, .smbusConfigMode, .hubConfigured, .hubSuspended,
        .suspendIndicatorOut, .reportSelfPowered, .attachState,
        .port1Fixed, .port2Fixed, .strapReserved, .awvalid, .awready,
        .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
        .rready, .rdata, .rresp
    );
    hub_board_model board (
        .sharedPinOut, .sharedPinOe, .senseMode(smbusConfigMode), .strapLo,
        .strapHi, .supply, .sharedPinIn, .strapMsbPinIn
    );
    always #10 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic rst(input logic smb, input logic [1:0] s);
        @(posedge clk);
        reset <= 1'b1;
        smbusConfigMode <= smb;
        {strapHi, strapLo} <= s;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : rst
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        {awvalid, wvalid, bready} <= 3'b111;
        awaddr <= a;
        wdata <= d;
        while (pa || pw) begin
            @(posedge clk);
            if (awready === 1'b1) pa = 1'b0;
            if (wready === 1'b1) pw = 1'b0;
            awvalid <= pa;
            wvalid <= pw;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        {arvalid, rready} <= 2'b11;
        araddr <= a;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axr
    task automatic test_strap;
        for (int c = 0; c < 4; c++) begin
            logic [2:0] e;
            e = {c == 2, c == 1 || c == 2, c == 3};
            rst(1'b0, c[1:0]);
            chk({port2Fixed, port1Fixed, strapReserved}, e);
            axr(`HSP_OFF_STATUS);
            chk(rd[`HSP_ST_STRAP_HI:`HSP_ST_STRAP_LO], c[1:0]);
            chk(rd[`HSP_ST_ROLE_HI:`HSP_ST_ROLE_LO], 2'h1);
            {strapHi, strapLo} <= ~c[1:0];
            repeat (4) @(posedge clk);
            chk({port2Fixed, port1Fixed, strapReserved}, e);
            hubConfigured <= 1'b1;
            repeat (2) @(posedge clk);
            chk({suspendIndicatorOut, sharedPinOe, sharedPinOut},
                {2'b11, ~c[0]});
            hubSuspended <= 1'b1;
            repeat (2) @(posedge clk);
            chk({suspendIndicatorOut, sharedPinOut}, {1'b0, c[0]});
            {hubConfigured, hubSuspended} <= 2'b00;
            repeat (2) @(posedge clk);
            chk(suspendIndicatorOut, 1'b0);
        end
        $display("test strap done");
    endtask : test_strap
    task automatic test_smbus;
        supply <= 1'b1;
        rst(1'b1, 2'b11);
        chk({sharedPinOe, port1Fixed, port2Fixed, strapReserved}, 4'h0);
        axr(`HSP_OFF_STATUS);
        chk(rd[`HSP_ST_LOCAL], 1'b1);
        axw(`HSP_OFF_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(reportSelfPowered, 1'b1);
        supply <= 1'b0;
        repeat (6) @(posedge clk);
        chk(reportSelfPowered, 1'b0);
        supply <= 1'b1;
        repeat (6) @(posedge clk);
        axw(`HSP_OFF_CTRL, 32'h0000_0005);
        chk(attachState, 1'b1);
        supply <= 1'b0;
        repeat (8) @(posedge clk);
        chk(reportSelfPowered, 1'b1);
        axr(`HSP_OFF_STATUS);
        chk(rd[8:2], 7'h6f);
        axw(`HSP_OFF_CTRL, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk({attachState, reportSelfPowered}, 2'b11);
        axw(`HSP_OFF_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk(reportSelfPowered, 1'b0);
        $display("test smbus done");
    endtask : test_smbus
    task automatic test_bus;
        rst(1'b0, 2'b00);
        axr(`HSP_OFF_CTRL);
        chk({resp, rd[2:0]}, {`HSP_RESP_OKAY, `HSP_CTRL_RESET});
        axr(8'h08);
        chk({resp, rd}, {`HSP_RESP_SLVERR, 32'h0000_0000});
        axw(8'h0c, 32'hffff_ffff);
        chk(resp, `HSP_RESP_SLVERR);
        axw(`HSP_OFF_STATUS, 32'hffff_ffff);
        chk(resp, `HSP_RESP_OKAY);
        axr(`HSP_OFF_CTRL);
        chk(rd, 32'h0000_0000);
        $display("test bus done");
    endtask : test_bus
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_sim;
        end
    end
    initial begin
        {clk, ce, reset, smbusConfigMode, hubConfigured, hubSuspended} = 6'h18;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, awprot, arprot} = '0;
        {strapLo, strapHi, supply} = '0;
        wstrb = 4'hf;
        n_fail = 0;
        checks = 0;
        cyc = 0;
        test_strap;
        test_smbus;
        test_bus;
        end_sim;
    end
endmodule : testbench
`default_nettype wire
